// ===== aex_core.sv
// execution unit for unary arithmetic, multiplies and program flow, APB registers
`timescale 1ns/1ps
`default_nettype none
`include "aex_params.svh"

module aex_core #(
  parameter int K_W = 12,
  parameter int STACK_DEPTH = 16
) (
  input wire logic pclk, // 250 MHz clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic busy, // instruction in progress
  output logic [15:0] pc_out // program counter
);
  import aex_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH) + 1;

  // ==========================================================
  // state
  aex_state_t st_q, st_d;
  aex_opnd_t opnd_q, opnd_d;
  logic [K_W-1:0] offs_q, offs_d;
  logic [15:0] pc_q, pc_d, zptr_q, zptr_d, prod_q, prod_d;
  logic [7:0] flags_q, flags_d, iov_q, iov_d, res_q, res_d;
  logic [5:0] op_q, op_d;
  logic ill_q, ill_d;
  logic [2:0] cyc_q, cyc_d, cnt_q, cnt_d;
  logic [SP_W-1:0] sp_q, sp_d;
  logic [15:0] stack_q [STACK_DEPTH];
  logic [15:0] stack_d [STACK_DEPTH];
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  logic [SP_W-1:0] sp_m1;
  logic [15:0] top, koff;
  logic acc, wr_fire;
  aex_outcome_t oc;

  assign sp_m1 = sp_q - 1'b1;
  assign top = stack_q[sp_m1[SP_W-2:0]];
  assign koff = {{(16 - K_W){offs_q[K_W-1]}}, offs_q};
  assign acc = psel & penable;
  // a refused transfer never lands, even if the unit went idle meanwhile
  assign wr_fire = acc & pwrite & pready_q & ~pslverr_q;

  // ==========================================================
  // instruction evaluation
  function automatic aex_outcome_t aex_run(input aex_op_t op, input aex_opnd_t o,
                                           input logic [15:0] k, input logic [15:0] pc,
                                           input logic [15:0] zp, input logic [15:0] tp,
                                           input logic [7:0] fl, input logic [7:0] io);
    aex_outcome_t r;
    logic [15:0] a, b, p;
    logic [8:0] d;
    logic [7:0] x, s;
    logic cin, hit, skip;
    r.legal = 1'b1;
    r.res = 8'h00;
    r.prod = 16'h0000;
    r.flags = fl;
    r.pc = pc + `AEX_ONE16;
    r.cyc = `AEX_CYC_1;
    a = {8'h00, o.rd};
    b = {8'h00, o.rr};
    p = 16'h0000;
    d = 9'h000;
    x = 8'h00;
    s = o.rr;
    cin = 1'b0;
    hit = 1'b0;
    skip = 1'b0;
    case (op)
      AEX_OP_ADD_ONE, AEX_OP_SUB_ONE, AEX_OP_TEST_SIGN_ZERO, AEX_OP_ZERO_REGISTER: begin
        case (op)
          AEX_OP_ADD_ONE: x = o.rd + 8'h01;
          AEX_OP_SUB_ONE: x = o.rd - 8'h01;
          AEX_OP_TEST_SIGN_ZERO: x = o.rd & o.rd;
          default: x = o.rd ^ o.rd;
        endcase
        r.res = x;
        r.flags[`AEX_FL_Z] = (x == 8'h00);
        r.flags[`AEX_FL_N] = x[7];
        r.flags[`AEX_FL_V] = (op == AEX_OP_ADD_ONE) ? (x == `AEX_MIN_NEG) :
                             (op == AEX_OP_SUB_ONE) ? (x == `AEX_MAX_POS) : 1'b0;
      end
      AEX_OP_SET_ALL_ONES: r.res = `AEX_ALL_ONES;
      AEX_OP_PRODUCT_UNSIGNED, AEX_OP_PRODUCT_SIGNED, AEX_OP_PRODUCT_MIXED,
      AEX_OP_FRAC_PRODUCT_UNSIGNED, AEX_OP_FRAC_PRODUCT_SIGNED,
      AEX_OP_FRAC_PRODUCT_MIXED: begin
        if (op != AEX_OP_PRODUCT_UNSIGNED && op != AEX_OP_FRAC_PRODUCT_UNSIGNED) begin
          a = {{8{o.rd[7]}}, o.rd};
        end
        if (op == AEX_OP_PRODUCT_SIGNED || op == AEX_OP_FRAC_PRODUCT_SIGNED) begin
          b = {{8{o.rr[7]}}, o.rr};
        end
        p = a * b;
        r.flags[`AEX_FL_C] = p[15];
        if (op >= AEX_OP_FRAC_PRODUCT_UNSIGNED) begin
          p = {p[14:0], 1'b0};
        end
        r.prod = p;
        r.flags[`AEX_FL_Z] = (p == 16'h0000);
        r.cyc = `AEX_CYC_2;
      end
      AEX_OP_RELATIVE_JUMP, AEX_OP_RELATIVE_CALL: begin
        r.pc = pc + k + `AEX_ONE16;
        r.cyc = (op == AEX_OP_RELATIVE_JUMP) ? `AEX_CYC_2 : `AEX_CYC_3;
      end
      AEX_OP_INDIRECT_JUMP, AEX_OP_INDIRECT_CALL: begin
        r.pc = zp;
        r.cyc = (op == AEX_OP_INDIRECT_JUMP) ? `AEX_CYC_2 : `AEX_CYC_3;
      end
      AEX_OP_SUBROUTINE_EXIT, AEX_OP_INTERRUPT_EXIT: begin
        r.pc = tp;
        r.cyc = `AEX_CYC_4;
        if (op == AEX_OP_INTERRUPT_EXIT) begin
          r.flags[`AEX_FL_I] = 1'b1;
        end
      end
      AEX_OP_COMPARE_REGS, AEX_OP_COMPARE_WITH_BORROW, AEX_OP_COMPARE_IMMEDIATE: begin
        if (op == AEX_OP_COMPARE_IMMEDIATE) begin
          s = o.imm;
        end
        cin = (op == AEX_OP_COMPARE_WITH_BORROW) & fl[`AEX_FL_C];
        d = {1'b0, o.rd} - {1'b0, s} - {8'h00, cin};
        x = d[7:0];
        r.flags[`AEX_FL_C] = d[8];
        r.flags[`AEX_FL_N] = x[7];
        r.flags[`AEX_FL_V] = (o.rd[7] & ~s[7] & ~x[7]) | (~o.rd[7] & s[7] & x[7]);
        r.flags[`AEX_FL_H] = (~o.rd[3] & s[3]) | (s[3] & x[3]) | (x[3] & ~o.rd[3]);
        r.flags[`AEX_FL_Z] = (op == AEX_OP_COMPARE_WITH_BORROW) ?
                             ((x == 8'h00) & fl[`AEX_FL_Z]) : (x == 8'h00);
      end
      AEX_OP_COMPARE_SKIP_EQUAL: skip = (o.rd == o.rr);
      AEX_OP_SKIP_REG_BIT_CLEAR: skip = ~o.rr[o.bit_sel];
      AEX_OP_SKIP_REG_BIT_SET: skip = o.rr[o.bit_sel];
      AEX_OP_SKIP_IO_BIT_CLEAR: skip = ~io[o.bit_sel];
      AEX_OP_SKIP_IO_BIT_SET: skip = io[o.bit_sel];
      AEX_OP_BRANCH_FLAG_SET: hit = fl[o.bit_sel];
      AEX_OP_BRANCH_FLAG_CLEAR: hit = ~fl[o.bit_sel];
      AEX_OP_BRANCH_EQUAL: hit = fl[`AEX_FL_Z];
      AEX_OP_BRANCH_NOT_EQUAL: hit = ~fl[`AEX_FL_Z];
      AEX_OP_BRANCH_CARRY_SET, AEX_OP_BRANCH_LOWER: hit = fl[`AEX_FL_C];
      AEX_OP_BRANCH_CARRY_CLEAR, AEX_OP_BRANCH_SAME_HIGHER: begin
        hit = ~fl[`AEX_FL_C];
      end
      AEX_OP_BRANCH_MINUS: hit = fl[`AEX_FL_N];
      AEX_OP_BRANCH_PLUS: hit = ~fl[`AEX_FL_N];
      AEX_OP_BRANCH_SIGNED_GE: hit = ~(fl[`AEX_FL_N] ^ fl[`AEX_FL_V]);
      AEX_OP_BRANCH_SIGNED_LT: hit = fl[`AEX_FL_N] ^ fl[`AEX_FL_V];
      AEX_OP_BRANCH_HALF_SET: hit = fl[`AEX_FL_H];
      AEX_OP_BRANCH_HALF_CLEAR: hit = ~fl[`AEX_FL_H];
      AEX_OP_BRANCH_TFLAG_SET: hit = fl[`AEX_FL_T];
      AEX_OP_BRANCH_TFLAG_CLEAR: hit = ~fl[`AEX_FL_T];
      default: r.legal = 1'b0;
    endcase
    if (skip) begin
      r.pc = pc + (o.two_word ? `AEX_SKIP_LONG : `AEX_SKIP_SHORT);
      r.cyc = o.two_word ? `AEX_CYC_3 : `AEX_CYC_2;
    end
    if (hit) begin
      r.pc = pc + k + `AEX_ONE16;
      r.cyc = `AEX_CYC_2;
    end
    return r;
  endfunction : aex_run

  assign oc = aex_run(aex_op_t'(pwdata[5:0]), opnd_q, koff, pc_q, zptr_q, top,
                      flags_q, iov_q);

  // ==========================================================
  // core next state
  always_comb begin
    st_d = st_q;
    opnd_d = opnd_q;
    offs_d = offs_q;
    pc_d = pc_q;
    zptr_d = zptr_q;
    prod_d = prod_q;
    flags_d = flags_q;
    iov_d = iov_q;
    res_d = res_q;
    op_d = op_q;
    ill_d = ill_q;
    cyc_d = cyc_q;
    cnt_d = cnt_q;
    sp_d = sp_q;
    stack_d = stack_q;
    case (st_q)
      AEX_IDLE: begin
        if (wr_fire) begin
          case (paddr)
            `AEX_OFF_CTRL: begin
              op_d = pwdata[5:0];
              ill_d = ~oc.legal;
              if (oc.legal) begin
                pc_d = oc.pc;
                flags_d = oc.flags;
                cyc_d = oc.cyc;
                cnt_d = oc.cyc;
                st_d = AEX_BUSY;
                if (pwdata[5:0] <= AEX_OP_SET_ALL_ONES) begin
                  res_d = oc.res;
                end
                if (pwdata[5:0] >= AEX_OP_PRODUCT_UNSIGNED &&
                    pwdata[5:0] <= AEX_OP_FRAC_PRODUCT_MIXED) begin
                  prod_d = oc.prod;
                end
                if (pwdata[5:0] == AEX_OP_RELATIVE_CALL ||
                    pwdata[5:0] == AEX_OP_INDIRECT_CALL) begin
                  stack_d[sp_q[SP_W-2:0]] = pc_q + `AEX_ONE16;
                  sp_d = sp_q + 1'b1;
                end
                if (pwdata[5:0] == AEX_OP_SUBROUTINE_EXIT ||
                    pwdata[5:0] == AEX_OP_INTERRUPT_EXIT) begin
                  sp_d = sp_m1;
                end
              end
            end
            `AEX_OFF_OPND: opnd_d = pwdata;
            `AEX_OFF_OFFS: offs_d = pwdata[K_W-1:0];
            `AEX_OFF_PC: pc_d = pwdata[15:0];
            `AEX_OFF_ZPTR: zptr_d = pwdata[15:0];
            `AEX_OFF_FLAGS: flags_d = pwdata[7:0];
            `AEX_OFF_IOV: iov_d = pwdata[7:0];
            default: ;
          endcase
        end
      end
      AEX_BUSY: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == `AEX_CYC_1) begin
          st_d = AEX_IDLE;
        end
      end
      default: st_d = AEX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= AEX_IDLE;
      opnd_q <= '0;
      offs_q <= '0;
      pc_q <= `AEX_PC_RST;
      zptr_q <= 16'h0000;
      prod_q <= 16'h0000;
      flags_q <= `AEX_FLAGS_RST;
      iov_q <= 8'h00;
      res_q <= 8'h00;
      op_q <= 6'h00;
      ill_q <= 1'b0;
      cyc_q <= 3'h0;
      cnt_q <= 3'h0;
      sp_q <= '0;
      stack_q <= '{default: 16'h0000};
      busy <= 1'b0;
      pc_out <= `AEX_PC_RST;
    end else if (ce) begin
      st_q <= st_d;
      opnd_q <= opnd_d;
      offs_q <= offs_d;
      pc_q <= pc_d;
      zptr_q <= zptr_d;
      prod_q <= prod_d;
      flags_q <= flags_d;
      iov_q <= iov_d;
      res_q <= res_d;
      op_q <= op_d;
      ill_q <= ill_d;
      cyc_q <= cyc_d;
      cnt_q <= cnt_d;
      sp_q <= sp_d;
      stack_q <= stack_d;
      busy <= (st_d == AEX_BUSY);
      pc_out <= pc_d;
    end
  end

  // ==========================================================
  // apb slave: ready one cycle into the access phase
  always_comb begin
    pready_d = acc & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (acc && !pready_q) begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        `AEX_OFF_CTRL: prdata_d = {22'h00_0000, ill_q, (st_q == AEX_BUSY), 2'h0, op_q};
        `AEX_OFF_OPND: prdata_d = opnd_q;
        `AEX_OFF_OFFS: prdata_d = {{(32 - K_W){1'b0}}, offs_q};
        `AEX_OFF_PC: prdata_d = {16'h0000, pc_q};
        `AEX_OFF_ZPTR: prdata_d = {16'h0000, zptr_q};
        `AEX_OFF_FLAGS: prdata_d = {24'h00_0000, flags_q};
        `AEX_OFF_IOV: prdata_d = {24'h00_0000, iov_q};
        `AEX_OFF_RES: prdata_d = {24'h00_0000, res_q};
        `AEX_OFF_PROD: prdata_d = {16'h0000, prod_q};
        `AEX_OFF_STACK: prdata_d = {top, {(16 - SP_W){1'b0}}, sp_q};
        `AEX_OFF_CYC: prdata_d = {29'h0000_0000, cyc_q};
        default: pslverr_d = 1'b1;
      endcase
      // writes to offsets up to 0x18 while an instruction runs are refused
      if (pwrite && st_q == AEX_BUSY && paddr <= `AEX_OFF_IOV) begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

endmodule : aex_core
`default_nettype wire

// ===== aex_params.svh
// constants of the arithmetic and program-flow execution unit
`ifndef AEX_PARAMS_SVH
`define AEX_PARAMS_SVH

// ============================================================
// register byte offsets
`define AEX_OFF_CTRL 8'h00
`define AEX_OFF_OPND 8'h04
`define AEX_OFF_OFFS 8'h08
`define AEX_OFF_PC 8'h0c
`define AEX_OFF_ZPTR 8'h10
`define AEX_OFF_FLAGS 8'h14
`define AEX_OFF_IOV 8'h18
`define AEX_OFF_RES 8'h1c
`define AEX_OFF_PROD 8'h20
`define AEX_OFF_STACK 8'h24
`define AEX_OFF_CYC 8'h28

// ============================================================
// flag register bit positions
`define AEX_FL_C 0
`define AEX_FL_Z 1
`define AEX_FL_N 2
`define AEX_FL_V 3
`define AEX_FL_S 4
`define AEX_FL_H 5
`define AEX_FL_T 6
`define AEX_FL_I 7

// ============================================================
// control register fields
`define AEX_CTRL_BUSY 8
`define AEX_CTRL_ILL 9

// ============================================================
// reset values and constants
`define AEX_PC_RST 16'h0000
`define AEX_FLAGS_RST 8'h00
`define AEX_ALL_ONES 8'hff
`define AEX_MIN_NEG 8'h80
`define AEX_MAX_POS 8'h7f
`define AEX_ONE16 16'h0001
`define AEX_SKIP_SHORT 16'h0002
`define AEX_SKIP_LONG 16'h0003

// ============================================================
// cycle counts
`define AEX_CYC_1 3'h1
`define AEX_CYC_2 3'h2
`define AEX_CYC_3 3'h3
`define AEX_CYC_4 3'h4

`endif

// ===== aex_pkg.sv
// types of the arithmetic and program-flow execution unit
`default_nettype none
package aex_pkg;

  typedef enum logic [5:0] {
    AEX_OP_ADD_ONE = 6'h00, AEX_OP_SUB_ONE = 6'h01, AEX_OP_TEST_SIGN_ZERO = 6'h02,
    AEX_OP_ZERO_REGISTER = 6'h03, AEX_OP_SET_ALL_ONES = 6'h04,
    AEX_OP_PRODUCT_UNSIGNED = 6'h05, AEX_OP_PRODUCT_SIGNED = 6'h06,
    AEX_OP_PRODUCT_MIXED = 6'h07, AEX_OP_FRAC_PRODUCT_UNSIGNED = 6'h08,
    AEX_OP_FRAC_PRODUCT_SIGNED = 6'h09, AEX_OP_FRAC_PRODUCT_MIXED = 6'h0a,
    AEX_OP_RELATIVE_JUMP = 6'h0b, AEX_OP_INDIRECT_JUMP = 6'h0c,
    AEX_OP_RELATIVE_CALL = 6'h0d, AEX_OP_INDIRECT_CALL = 6'h0e,
    AEX_OP_SUBROUTINE_EXIT = 6'h0f, AEX_OP_INTERRUPT_EXIT = 6'h10,
    AEX_OP_COMPARE_SKIP_EQUAL = 6'h11, AEX_OP_COMPARE_REGS = 6'h12,
    AEX_OP_COMPARE_WITH_BORROW = 6'h13, AEX_OP_COMPARE_IMMEDIATE = 6'h14,
    AEX_OP_SKIP_REG_BIT_CLEAR = 6'h15, AEX_OP_SKIP_REG_BIT_SET = 6'h16,
    AEX_OP_SKIP_IO_BIT_CLEAR = 6'h17, AEX_OP_SKIP_IO_BIT_SET = 6'h18,
    AEX_OP_BRANCH_FLAG_SET = 6'h19, AEX_OP_BRANCH_FLAG_CLEAR = 6'h1a,
    AEX_OP_BRANCH_EQUAL = 6'h1b, AEX_OP_BRANCH_NOT_EQUAL = 6'h1c,
    AEX_OP_BRANCH_CARRY_SET = 6'h1d, AEX_OP_BRANCH_CARRY_CLEAR = 6'h1e,
    AEX_OP_BRANCH_SAME_HIGHER = 6'h1f, AEX_OP_BRANCH_LOWER = 6'h20,
    AEX_OP_BRANCH_MINUS = 6'h21, AEX_OP_BRANCH_PLUS = 6'h22,
    AEX_OP_BRANCH_SIGNED_GE = 6'h23, AEX_OP_BRANCH_SIGNED_LT = 6'h24,
    AEX_OP_BRANCH_HALF_SET = 6'h25, AEX_OP_BRANCH_HALF_CLEAR = 6'h26,
    AEX_OP_BRANCH_TFLAG_SET = 6'h27, AEX_OP_BRANCH_TFLAG_CLEAR = 6'h28
  } aex_op_t;

  typedef enum logic [1:0] {
    AEX_IDLE = 2'b01,
    AEX_BUSY = 2'b10
  } aex_state_t;

  // operand register layout
  typedef struct packed {
    logic [3:0] rsvd;
    logic two_word;
    logic [2:0] bit_sel;
    logic [7:0] imm;
    logic [7:0] rr;
    logic [7:0] rd;
  } aex_opnd_t;

  // outcome of one instruction
  typedef struct packed {
    logic legal;
    logic [7:0] res;
    logic [15:0] prod;
    logic [7:0] flags;
    logic [15:0] pc;
    logic [2:0] cyc;
  } aex_outcome_t;

endpackage : aex_pkg
`default_nettype wire

// ===== aex_core_monitor.sv
// concurrent checks on the execution unit ports
`timescale 1ns/1ps
`default_nettype none

module aex_core_monitor #(
  parameter int K_W = 12,
  parameter int STACK_DEPTH = 16
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic busy, // instruction in progress
  input wire logic [15:0] pc_out // program counter
);
  // ============================================================
  // helper decode
  logic wr_done;
  logic start;
  logic pc_wr;
  logic [5:0] op;
  assign wr_done = psel && penable && pready && pwrite;
  assign start = wr_done && !pslverr && (paddr == 8'h00) && !busy;
  assign pc_wr = wr_done && (paddr == 8'h0c);
  assign op = pwdata[5:0];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !ce);

  // ============================================================
  // bus and execution timing
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_one_wait: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_unmapped_err: assert property (pready && paddr > 8'h28 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_busy_refuse: assert property (wr_done && busy && paddr <= 8'h18 |-> pslverr)
    else $error("write while busy accepted");
  a_unary_cycle: assert property (start && op <= 6'h04 |=> busy ##1 !busy)
    else $error("unary busy length wrong");
  a_mult_cycle: assert property (start && op >= 6'h05 && op <= 6'h0a |=>
    busy [*2] ##1 !busy) else $error("multiply busy length wrong");
  a_jump_cycle: assert property ((start && (op == 6'h0b || op == 6'h0c)) |=>
    busy [*2] ##1 !busy) else $error("jump busy length wrong");
  a_call_cycle: assert property ((start && (op == 6'h0d || op == 6'h0e)) |=>
    busy [*3] ##1 !busy) else $error("call busy length wrong");
  a_exit_cycle: assert property ((start && (op == 6'h0f || op == 6'h10)) |=>
    busy [*4] ##1 !busy) else $error("return busy length wrong");
  a_cmp_cycle: assert property (start && op >= 6'h12 && op <= 6'h14 |=> busy ##1 !busy)
    else $error("compare busy length wrong");
  a_branch_cycle: assert property (start && op >= 6'h19 && op <= 6'h28 |=>
    busy ##1 ((!busy) or (busy ##1 !busy))) else $error("branch busy length wrong");
  a_skip_cycle: assert property ((start && (op == 6'h11 || (op >= 6'h15 && op <= 6'h18))) |=>
    busy ##1 ((!busy) or (busy ##1 !busy) or (busy [*2] ##1 !busy)))
    else $error("skip busy length wrong");
  a_illegal_idle: assert property (start && op > 6'h28 |=> !busy [*2])
    else $error("illegal opcode started");
  a_pc_steady: assert property (!start && !pc_wr ##1 !start && !pc_wr |=> $stable(pc_out))
    else $error("pc moved without cause");
endmodule : aex_core_monitor

bind aex_core aex_core_monitor #(.K_W(K_W), .STACK_DEPTH(STACK_DEPTH)) u_mon (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busy(busy), .pc_out(pc_out)
);

`default_nettype wire

// ===== aex_core_tb.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none

module aex_core_tb;
  import aex_pkg::*;
  typedef struct packed {
    logic [5:0] op;
    logic [31:0] opnd;
    logic [7:0] fl;
    logic [15:0] pc;
    logic [7:0] xfl;
    logic [2:0] cyc;
    logic [15:0] val;
  } aex_row_t;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, busy, err_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [15:0] pc_out;
  int n_errors = 0;
  int n_checks = 0;
  aex_row_t r;
  // pc starts at 0x0100, offset -16: taken 0x00f1, not taken 0x0101
  aex_row_t rows [43] = '{
    '{6'h00, 32'h7f, 8'h00, 16'h0, 8'h0c, 3'h1, 16'h80},
    '{6'h01, 32'h80, 8'h01, 16'h0, 8'h09, 3'h1, 16'h7f},
    '{6'h02, 32'h00, 8'h0c, 16'h0, 8'h02, 3'h1, 16'h00},
    '{6'h03, 32'h95, 8'h04, 16'h0, 8'h02, 3'h1, 16'h00},
    '{6'h04, 32'h12, 8'h2f, 16'h0, 8'h2f, 3'h1, 16'hff},
    '{6'h05, 32'hffff, 8'h02, 16'h0, 8'h01, 3'h2, 16'hfe01},
    '{6'h06, 32'h02ff, 8'h00, 16'h0, 8'h01, 3'h2, 16'hfffe},
    '{6'h07, 32'hff80, 8'h00, 16'h0, 8'h01, 3'h2, 16'h8080},
    '{6'h08, 32'h8080, 8'h03, 16'h0, 8'h00, 3'h2, 16'h8000},
    '{6'h09, 32'h02ff, 8'h00, 16'h0, 8'h01, 3'h2, 16'hfffc},
    '{6'h0a, 32'hff02, 8'h03, 16'h0, 8'h00, 3'h2, 16'h03fc},
    '{6'h0b, 32'h0, 8'hff, 16'h00f1, 8'hff, 3'h2, 16'h0},
    '{6'h0c, 32'h0, 8'h00, 16'h1234, 8'h00, 3'h2, 16'h0},
    '{6'h0d, 32'h0, 8'h00, 16'h00f1, 8'h00, 3'h3, 16'h0},
    '{6'h0f, 32'h0, 8'h00, 16'h0101, 8'h00, 3'h4, 16'h0},
    '{6'h0e, 32'h0, 8'h01, 16'h1234, 8'h01, 3'h3, 16'h0},
    '{6'h10, 32'h0, 8'h01, 16'h0101, 8'h81, 3'h4, 16'h0},
    '{6'h11, 32'h3333, 8'h00, 16'h0102, 8'h00, 3'h2, 16'h0},
    '{6'h11, 32'h0800_3333, 8'h00, 16'h0103, 8'h00, 3'h3, 16'h0},
    '{6'h11, 32'h0800_3433, 8'h3f, 16'h0101, 8'h3f, 3'h1, 16'h0},
    '{6'h15, 32'h0400_1010, 8'h00, 16'h0101, 8'h00, 3'h1, 16'h0},
    '{6'h16, 32'h0400_1010, 8'h00, 16'h0102, 8'h00, 3'h2, 16'h0},
    '{6'h17, 32'h0700_0000, 8'h00, 16'h0101, 8'h00, 3'h1, 16'h0},
    '{6'h18, 32'h0f00_0000, 8'h00, 16'h0103, 8'h00, 3'h3, 16'h0},
    '{6'h12, 32'h2010, 8'h00, 16'h0, 8'h05, 3'h1, 16'h0},
    '{6'h13, 32'h0405, 8'h03, 16'h0, 8'h02, 3'h1, 16'h0},
    '{6'h14, 32'h0001_0080, 8'h00, 16'h0, 8'h28, 3'h1, 16'h0},
    '{6'h19, 32'h0600_0000, 8'h40, 16'h00f1, 8'h40, 3'h2, 16'h0},
    '{6'h1a, 32'h0300_0000, 8'h08, 16'h0101, 8'h08, 3'h1, 16'h0},
    '{6'h1b, 32'h0, 8'h02, 16'h00f1, 8'h02, 3'h2, 16'h0},
    '{6'h1c, 32'h0, 8'h02, 16'h0101, 8'h02, 3'h1, 16'h0},
    '{6'h1d, 32'h0, 8'h00, 16'h0101, 8'h00, 3'h1, 16'h0},
    '{6'h1e, 32'h0, 8'h00, 16'h00f1, 8'h00, 3'h2, 16'h0},
    '{6'h1f, 32'h0, 8'h01, 16'h0101, 8'h01, 3'h1, 16'h0},
    '{6'h20, 32'h0, 8'h01, 16'h00f1, 8'h01, 3'h2, 16'h0},
    '{6'h21, 32'h0, 8'h04, 16'h00f1, 8'h04, 3'h2, 16'h0},
    '{6'h22, 32'h0, 8'h04, 16'h0101, 8'h04, 3'h1, 16'h0},
    '{6'h23, 32'h0, 8'h0c, 16'h00f1, 8'h0c, 3'h2, 16'h0},
    '{6'h24, 32'h0, 8'h08, 16'h00f1, 8'h08, 3'h2, 16'h0},
    '{6'h25, 32'h0, 8'h00, 16'h0101, 8'h00, 3'h1, 16'h0},
    '{6'h26, 32'h0, 8'hdf, 16'h00f1, 8'hdf, 3'h2, 16'h0},
    '{6'h27, 32'h0, 8'hbf, 16'h0101, 8'hbf, 3'h1, 16'h0},
    '{6'h28, 32'h0, 8'h40, 16'h0101, 8'h40, 3'h1, 16'h0}
  };

  aex_core uut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .pc_out(pc_out)
  );

  // ============================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle;
    @(posedge pclk);
    while (busy !== 1'b0) @(posedge pclk);
  endtask : wait_idle

  task automatic end_sim;
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // ============================================================
  // clock, watchdog, main sequence
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h08, 32'h0000_0ff0);
    apb(1'b1, 8'h10, 32'h0000_1234);
    apb(1'b1, 8'h18, 32'h0000_0080);
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, 8'h04, r.opnd);
      if (r.op != 6'h0f && r.op != 6'h10) apb(1'b1, 8'h0c, 32'h0000_0100);
      apb(1'b1, 8'h14, 32'(r.fl));
      apb(1'b1, 8'h00, 32'(r.op));
      wait_idle();
      apb(1'b0, 8'h28, 32'h0);
      chk("cycles", 32'(r.cyc), rd_q);
      apb(1'b0, 8'h14, 32'h0);
      chk("flags", 32'(r.xfl), rd_q);
      if (r.op > 6'h0a && (r.op < 6'h12 || r.op > 6'h14)) chk("pc", 32'(r.pc), 32'(pc_out));
      if (r.op <= 6'h0a) begin
        apb(1'b0, (r.op <= 6'h04) ? 8'h1c : 8'h20, 32'h0);
        chk("result", 32'(r.val), rd_q);
      end
    end
    // ============================================================
    // unmapped, illegal opcode, write while busy, frozen clock, reset
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, 32'(err_q));
    chk("unmapped data", 32'h0, rd_q);
    apb(1'b1, 8'h0c, 32'h0000_0200);
    apb(1'b1, 8'h00, 32'h0000_0029);
    @(posedge pclk);
    chk("illegal busy", 32'h0, 32'(busy));
    apb(1'b0, 8'h00, 32'h0);
    chk("illegal flag", 32'h1, 32'(rd_q[9]));
    chk("illegal pc", 32'h0000_0200, 32'(pc_out));
    apb(1'b1, 8'h00, 32'h0000_000f);
    apb(1'b1, 8'h0c, 32'h0000_0abc);
    chk("busy write err", 32'h1, 32'(err_q));
    wait_idle();
    n_checks++;
    if (pc_out === 16'h0abc) begin
      n_errors++;
      $display("Error pc after refused write expected not 0abc seen %h", pc_out);
    end
    // call from pc 0: busy ends between the refusal and the completing edge
    apb(1'b1, 8'h00, 32'h0000_000d);
    apb(1'b1, 8'h0c, 32'h0000_0abc);
    chk("late busy err", 32'h1, 32'(err_q));
    wait_idle();
    chk("late busy pc", 32'h0000_fff1, 32'(pc_out));
    apb(1'b1, 8'h00, 32'h0000_000b);
    ce <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("busy frozen", 32'h1, 32'(busy));
    ce <= 1'b1;
    wait_idle();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pc reset", 32'h0, 32'(pc_out));
    presetn <= 1'b1;
    apb(1'b0, 8'h14, 32'h0);
    chk("flags reset", 32'h0, rd_q);
    apb(1'b0, 8'h24, 32'h0);
    chk("stack reset", 32'h0, rd_q);
    end_sim();
  end
endmodule : aex_core_tb

`default_nettype wire
